// ==== design/scci_map.vh ====
// Register offsets, field positions and reset values of the capture and flag block.
`ifndef SCCI_MAP_VH
`define SCCI_MAP_VH
// Register byte addresses (word aligned, data in the low byte).
`define SCCI_CAP0_HIGH     8'h00
`define SCCI_CAP0_LOW      8'h04
`define SCCI_CAP1_HIGH     8'h08
`define SCCI_CAP1_LOW      8'h0C
`define SCCI_CAP2_HIGH     8'h10
`define SCCI_CAP2_LOW      8'h14
`define SCCI_OUT_MATRIX    8'h18
`define SCCI_MASK0         8'h1C
`define SCCI_MASK1         8'h20
`define SCCI_MASK2         8'h24
`define SCCI_FLAGS0        8'h28
`define SCCI_FLAGS1        8'h2C
`define SCCI_FLAGS2        8'h30
`define SCCI_INPUT_CTRL0   8'h34
`define SCCI_INPUT_CTRL1   8'h38
`define SCCI_INPUT_CTRL2   8'h3C
// Field positions.
`define SCCI_SOFT_TRIG_BIT 7
`define SCCI_CAP_EN_A_BIT  0
`define SCCI_SEL_A_BIT     1
`define SCCI_CAP_EN_B_BIT  2
`define SCCI_SEL_B_BIT     3
`define SCCI_CYC_END_BIT   0
`define SCCI_EV_A_BIT      3
`define SCCI_EV_B_BIT      4
`define SCCI_SYNC_ERR_BIT  5
`define SCCI_ACT_A_BIT     6
`define SCCI_ACT_B_BIT     7
`define SCCI_MASK_USED     8'h39
`define SCCI_FLAG_W1C      8'h39
// Reset values.
`define SCCI_RESET_BYTE    8'h00
`define SCCI_RESET_CAP     12'h000
`endif

// ==== design/scci_top.v ====
// Capture registers and interrupt flags of three stage controllers, and the ramp output matrix of the third.
//
// Summary of operation
// - Writing one to soft trigger bit copies counter into capture value.
// - Soft trigger bit reads one when latest capture was software triggered.
// - With capture enabled, each input event loads counter into capture value.
// - Capture is 12 bits; low byte read latches high byte into temp.
// - One shared temp byte serves all multi-byte registers.
// - High byte: trigger bit 7, bits 6:4 zero, capture 11:8 in 3:0.
// - Without soft trigger variant, capture registers are read-only.
// - Matrix bits 3:0 give output A level during ramps 3..0.
// - Matrix bits 7:4 give output B level during ramps 3..0.
// - Sync error flag with its enable raises interrupt request.
// - Event A or B with its enable raises interrupt request.
// - Cycle end flag with its enable raises interrupt request.
// - Output transitions set activity flags; writing one clears them.
// - Autorun controller mismatching predecessor timing sets sync error flag.
// - Qualifying external event A or B sets its event flag.
// - Event flags set and readable regardless of enables.
// - On each event record ramp number code in bits 2:1.
// - Completing whole waveform cycle sets cycle end flag.
// - Capture on an input part only while its enable bit is one.
// - Select zero routes input pin, one routes comparator output.
//
// Our own choices: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`include "scci_map.vh"

module scci_top #(
  parameter HAS_SOFT_TRIG = 1
) (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire [35:0] stage_counter_i,
  input  wire [2:0]  stage_input_pin_i,
  input  wire [5:0]  comparator_i,
  input  wire [5:0]  event_active_i,
  input  wire [2:0]  cycle_end_i,
  input  wire [2:0]  update_i,
  input  wire [2:0]  autorun_follow_i,
  input  wire [2:0]  stage_out_0_i,
  input  wire [2:0]  stage_out_1_i,
  input  wire [5:0]  ramp_index_i,
  output reg         third_ctrl_out_0_o,
  output reg         third_ctrl_out_1_o,
  output reg         third_ctrl_out_2_o,
  output reg         third_ctrl_out_3_o,
  output reg  [2:0]  irq_o
);

  // ==========================================================================
  // Register map, one byte per word in the low lane:
  //   0x00 / 0x04  capture of controller 0, high image and low byte.
  //   0x08 / 0x0C  capture of controller 1, high image and low byte.
  //   0x10 / 0x14  capture of controller 2, high image and low byte.
  //   0x18         ramp output matrix of the third controller.
  //   0x1C .. 0x24 interrupt enables, one register per controller.
  //   0x28 .. 0x30 interrupt flags, one register per controller.
  //   0x34 .. 0x3C input part control, one register per controller.
  // Everything else reads zero and ignores writes.
  //
  // Software must read a capture low byte before its high byte. The high
  // address returns the shared latch, not the live register, so a read of
  // any other low byte in between hands back the wrong controller's half.
  // That is the price of one shared latch instead of one per register.
  //
  // The waveform generator lives outside this block and reports its ramp
  // number, cycle end, update strobe and output levels on plain inputs.

  // ==========================================================================
  // Register state
  reg  [11:0] capture_value [0:2];
  reg  [2:0]  capture_soft_trigger;
  reg  [7:0]  temp_byte;
  reg  [7:0]  ramp_output_matrix;
  reg  [7:0]  irq_mask [0:2];
  reg  [7:0]  irq_flags [0:2];
  reg  [3:0]  input_part_control [0:2];
  reg  [2:0]  pin_s1;
  reg  [2:0]  pin_s2;
  reg  [2:0]  pin_s3;
  reg  [2:0]  pin_db;
  reg  [5:0]  cmp_s1;
  reg  [5:0]  cmp_s2;
  reg  [5:0]  cmp_s3;
  reg  [5:0]  cmp_db;
  reg  [5:0]  ev_level_q;
  reg  [2:0]  out0_q;
  reg  [2:0]  out1_q;
  reg  [7:0]  next_rdata;
  reg  [7:0]  next_flags [0:2];
  // Each process owns its loop index, so no variable has two drivers.
  integer     i_ev;
  integer     i_cfg;
  integer     i_cap;
  integer     i_flg;
  integer     i_nxt;
  integer     i_irq;

  wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr_req  = bus_req & wb_we_i & wb_sel_i[0];
  wire rd_req  = bus_req & ~wb_we_i;

  // ==========================================================================
  // Input synchronisers: three stages, a change counts once stages two and three agree.
  // The pins and comparators are asynchronous, so the first stage may go
  // metastable; only the second stage reads it. The filtered level holds its
  // old value while stages two and three disagree, which rejects a one-cycle
  // glitch at the cost of one more cycle of latency.
  always @(posedge clk_i) begin
    if (rst_i) begin
      pin_s1 <= 3'h0;
      pin_s2 <= 3'h0;
      pin_s3 <= 3'h0;
      pin_db <= 3'h0;
      cmp_s1 <= 6'h00;
      cmp_s2 <= 6'h00;
      cmp_s3 <= 6'h00;
      cmp_db <= 6'h00;
    end else begin
      pin_s1 <= stage_input_pin_i;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_db <= (pin_s2 & pin_s3) | (pin_db & (pin_s2 | pin_s3));
      cmp_s1 <= comparator_i;
      cmp_s2 <= cmp_s1;
      cmp_s3 <= cmp_s2;
      cmp_db <= (cmp_s2 & cmp_s3) | (cmp_db & (cmp_s2 | cmp_s3));
    end
  end

  // ==========================================================================
  // Event selection. Polarity comes from the waveform side as event_active_i
  // per part, so here an event is the rising of the qualified level.
  // Both parts of one controller may watch the same pin; each part has its
  // own comparator line.
  reg [5:0] ev_level;
  always @* begin
    ev_level = 6'h00;
    for (i_ev = 0; i_ev < 3; i_ev = i_ev + 1) begin
      ev_level[2*i_ev]   = event_active_i[2*i_ev] &
        (input_part_control[i_ev][`SCCI_SEL_A_BIT] ? cmp_db[2*i_ev] : pin_db[i_ev]);
      ev_level[2*i_ev+1] = event_active_i[2*i_ev+1] &
        (input_part_control[i_ev][`SCCI_SEL_B_BIT] ? cmp_db[2*i_ev+1] : pin_db[i_ev]);
    end
  end
  // A level that stays up gives a single event, not one per cycle.
  wire [5:0] ev_pulse = ev_level & ~ev_level_q;

  // ==========================================================================
  // Bus slave: one wait-free ack per request; reads return the low byte.
  // The ack answers one cycle after the request is seen and is never given
  // twice in a row, so a master that holds its strobe gets a transfer every second cycle.
  // Read data is registered and stays put until the next read.
  always @* begin
    next_rdata = `SCCI_RESET_BYTE;
    case (wb_adr_i)
      `SCCI_CAP0_HIGH:   next_rdata = temp_byte;
      `SCCI_CAP1_HIGH:   next_rdata = temp_byte;
      `SCCI_CAP2_HIGH:   next_rdata = temp_byte;
      `SCCI_CAP0_LOW:    next_rdata = capture_value[0][7:0];
      `SCCI_CAP1_LOW:    next_rdata = capture_value[1][7:0];
      `SCCI_CAP2_LOW:    next_rdata = capture_value[2][7:0];
      `SCCI_OUT_MATRIX:  next_rdata = ramp_output_matrix;
      `SCCI_MASK0:       next_rdata = irq_mask[0];
      `SCCI_MASK1:       next_rdata = irq_mask[1];
      `SCCI_MASK2:       next_rdata = irq_mask[2];
      `SCCI_FLAGS0:      next_rdata = irq_flags[0];
      `SCCI_FLAGS1:      next_rdata = irq_flags[1];
      `SCCI_FLAGS2:      next_rdata = irq_flags[2];
      `SCCI_INPUT_CTRL0: next_rdata = {4'h0, input_part_control[0]};
      `SCCI_INPUT_CTRL1: next_rdata = {4'h0, input_part_control[1]};
      `SCCI_INPUT_CTRL2: next_rdata = {4'h0, input_part_control[2]};
      default:           next_rdata = `SCCI_RESET_BYTE;
    endcase
  end

  // High byte image of a capture, used when the low byte is read.
  function [7:0] high_image;
    input        trig;
    input [11:0] val;
    begin
      high_image = {trig, 3'h0, val[11:8]};
    end
  endfunction

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o  <= 1'b0;
      wb_dat_o  <= 32'h0000_0000;
      temp_byte <= `SCCI_RESET_BYTE;
    end else begin
      wb_ack_o <= bus_req;
      if (rd_req)
        wb_dat_o <= {24'h00_0000, next_rdata};
      // Reading a low byte freezes its high half so a later high read is coherent.
      if (rd_req && wb_adr_i == `SCCI_CAP0_LOW)
        temp_byte <= high_image(capture_soft_trigger[0], capture_value[0]);
      else if (rd_req && wb_adr_i == `SCCI_CAP1_LOW)
        temp_byte <= high_image(capture_soft_trigger[1], capture_value[1]);
      else if (rd_req && wb_adr_i == `SCCI_CAP2_LOW)
        temp_byte <= high_image(capture_soft_trigger[2], capture_value[2]);
    end
  end

  // ==========================================================================
  // Configuration registers: matrix, masks and input part control.
  always @(posedge clk_i) begin
    if (rst_i) begin
      ramp_output_matrix <= `SCCI_RESET_BYTE;
      for (i_cfg = 0; i_cfg < 3; i_cfg = i_cfg + 1) begin
        irq_mask[i_cfg]           <= `SCCI_RESET_BYTE;
        input_part_control[i_cfg] <= 4'h0;
      end
    end else if (wr_req) begin
      case (wb_adr_i)
        `SCCI_OUT_MATRIX:  ramp_output_matrix <= wb_dat_i[7:0];
        `SCCI_MASK0:       irq_mask[0] <= wb_dat_i[7:0] & `SCCI_MASK_USED;
        `SCCI_MASK1:       irq_mask[1] <= wb_dat_i[7:0] & `SCCI_MASK_USED;
        `SCCI_MASK2:       irq_mask[2] <= wb_dat_i[7:0] & `SCCI_MASK_USED;
        `SCCI_INPUT_CTRL0: input_part_control[0] <= wb_dat_i[3:0];
        `SCCI_INPUT_CTRL1: input_part_control[1] <= wb_dat_i[3:0];
        `SCCI_INPUT_CTRL2: input_part_control[2] <= wb_dat_i[3:0];
        default:           ramp_output_matrix <= ramp_output_matrix;
      endcase
    end
  end

  // ==========================================================================
  // Capture registers. A hardware event wins over a soft trigger in the same
  // cycle, since the event is the one software cannot repeat.
  reg [2:0] soft_hit;
  always @* begin
    soft_hit[0] = wr_req && wb_adr_i == `SCCI_CAP0_HIGH && wb_dat_i[`SCCI_SOFT_TRIG_BIT];
    soft_hit[1] = wr_req && wb_adr_i == `SCCI_CAP1_HIGH && wb_dat_i[`SCCI_SOFT_TRIG_BIT];
    soft_hit[2] = wr_req && wb_adr_i == `SCCI_CAP2_HIGH && wb_dat_i[`SCCI_SOFT_TRIG_BIT];
  end

  // The counter is sampled in the cycle the qualified event is seen, so the
  // capture lags the pin by the synchroniser depth. Software that needs the
  // exact edge time must subtract that fixed latency itself.
  always @(posedge clk_i) begin
    if (rst_i) begin
      capture_soft_trigger <= 3'h0;
      for (i_cap = 0; i_cap < 3; i_cap = i_cap + 1)
        capture_value[i_cap] <= `SCCI_RESET_CAP;
    end else begin
      for (i_cap = 0; i_cap < 3; i_cap = i_cap + 1) begin
        if ((ev_pulse[2*i_cap] && input_part_control[i_cap][`SCCI_CAP_EN_A_BIT]) ||
            (ev_pulse[2*i_cap+1] && input_part_control[i_cap][`SCCI_CAP_EN_B_BIT])) begin
          capture_value[i_cap]        <= stage_counter_i[12*i_cap +: 12];
          capture_soft_trigger[i_cap] <= 1'b0;
        end else if (HAS_SOFT_TRIG != 0 && soft_hit[i_cap]) begin
          capture_value[i_cap]        <= stage_counter_i[12*i_cap +: 12];
          capture_soft_trigger[i_cap] <= 1'b1;
        end
      end
    end
  end

  // ==========================================================================
  // Flag next-state logic. Hardware sets take priority over a write-one clear
  // in the same cycle, so an event that lands while software clears is kept.
  reg [7:0] set_bits;
  reg [7:0] clr_bits;
  reg [7:0] flag_addr;
  reg [1:0] pred;
  always @* begin
    set_bits  = 8'h00;
    clr_bits  = 8'h00;
    flag_addr = `SCCI_FLAGS0;
    pred      = 2'd2;
    for (i_nxt = 0; i_nxt < 3; i_nxt = i_nxt + 1) begin
      // The first controller follows the third; the others follow the one below.
      flag_addr = (i_nxt == 0) ? `SCCI_FLAGS0 : (i_nxt == 1) ? `SCCI_FLAGS1 : `SCCI_FLAGS2;
      pred      = (i_nxt == 0) ? 2'd2 : i_nxt[1:0] - 2'd1;
      set_bits  = 8'h00;
      set_bits[`SCCI_CYC_END_BIT]  = cycle_end_i[i_nxt];
      set_bits[`SCCI_EV_A_BIT]     = ev_pulse[2*i_nxt];
      set_bits[`SCCI_EV_B_BIT]     = ev_pulse[2*i_nxt+1];
      // Strobes that should coincide but do not mark a drifting follower.
      set_bits[`SCCI_SYNC_ERR_BIT] = autorun_follow_i[i_nxt] &
        ((update_i[i_nxt] ^ update_i[pred]) | (cycle_end_i[i_nxt] ^ cycle_end_i[pred]));
      set_bits[`SCCI_ACT_A_BIT]    = stage_out_0_i[i_nxt] ^ out0_q[i_nxt];
      set_bits[`SCCI_ACT_B_BIT]    = stage_out_1_i[i_nxt] ^ out1_q[i_nxt];
      // The ramp code bits are left out of the clear mask: they are read-only.
      clr_bits = (wr_req && wb_adr_i == flag_addr) ?
                 (wb_dat_i[7:0] & (`SCCI_FLAG_W1C | 8'hC0)) : 8'h00;
      next_flags[i_nxt]      = (irq_flags[i_nxt] & ~clr_bits) | set_bits;
      // The ramp code only moves on an event and otherwise keeps the last one.
      next_flags[i_nxt][2:1] = (ev_pulse[2*i_nxt] | ev_pulse[2*i_nxt+1]) ?
                               ramp_index_i[2*i_nxt +: 2] : irq_flags[i_nxt][2:1];
    end
  end

  // Flag registers and the delayed copies used for edge detection. The copies
  // reset to the idle level of their inputs so no false edge follows reset.
  always @(posedge clk_i) begin
    if (rst_i) begin
      out0_q     <= 3'h0;
      out1_q     <= 3'h0;
      ev_level_q <= 6'h00;
      for (i_flg = 0; i_flg < 3; i_flg = i_flg + 1)
        irq_flags[i_flg] <= `SCCI_RESET_BYTE;
    end else begin
      out0_q     <= stage_out_0_i;
      out1_q     <= stage_out_1_i;
      ev_level_q <= ev_level;
      for (i_flg = 0; i_flg < 3; i_flg = i_flg + 1)
        irq_flags[i_flg] <= next_flags[i_flg];
    end
  end

  // ==========================================================================
  // Outputs of the third controller and interrupt requests, all registered.
  // Registering costs one cycle after a ramp change but keeps glitches from
  // the ramp code decode off the pins. The request is a level that stays up
  // until software clears the flag or the enable.
  always @(posedge clk_i) begin
    if (rst_i) begin
      third_ctrl_out_0_o <= 1'b0;
      third_ctrl_out_1_o <= 1'b0;
      third_ctrl_out_2_o <= 1'b0;
      third_ctrl_out_3_o <= 1'b0;
      irq_o              <= 3'h0;
    end else begin
      third_ctrl_out_0_o <= ramp_output_matrix[{1'b0, ramp_index_i[5:4]}];
      third_ctrl_out_2_o <= ramp_output_matrix[{1'b0, ramp_index_i[5:4]}];
      third_ctrl_out_1_o <= ramp_output_matrix[{1'b1, ramp_index_i[5:4]}];
      third_ctrl_out_3_o <= ramp_output_matrix[{1'b1, ramp_index_i[5:4]}];
      for (i_irq = 0; i_irq < 3; i_irq = i_irq + 1)
        irq_o[i_irq] <= |(irq_flags[i_irq] & irq_mask[i_irq]);
    end
  end

endmodule // scci_top

// ==== tb/scci_properties.sv ====
// Port-level assertions for the capture, output matrix and flag block.
`timescale 1ns/1ps

module scci_properties (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        third_ctrl_out_0_o,
  input wire logic        third_ctrl_out_1_o,
  input wire logic        third_ctrl_out_2_o,
  input wire logic        third_ctrl_out_3_o,
  input wire logic [2:0]  irq_o
);
  // ==========================================================================
  // Bus handshake and read data
  // All checks share the one clock; reset masks them except the reset check.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_answers_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged one cycle later");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge held longer than one cycle");
  a_ack_needs_req: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("acknowledge without a request");
  a_dat_read_only: assert property ($changed(wb_dat_o) |-> wb_ack_o && !wb_we_i)
    else $error("read data changed outside a read acknowledge");
  a_dat_upper_zero: assert property (wb_dat_o[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");
  // ==========================================================================
  // Output matrix pairs and reset
  a_out_a_pair: assert property (third_ctrl_out_0_o == third_ctrl_out_2_o)
    else $error("output A pair differs");
  a_out_b_pair: assert property (third_ctrl_out_1_o == third_ctrl_out_3_o)
    else $error("output B pair differs");
  // Reset must silence the ack, the irqs and outputs 0 and 1 at the very next edge.
  a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o && irq_o == 3'h0
    && !third_ctrl_out_0_o && !third_ctrl_out_1_o) else $error("outputs active after reset");
endmodule // scci_properties

bind scci_top scci_properties u_props (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .third_ctrl_out_0_o(third_ctrl_out_0_o), .third_ctrl_out_1_o(third_ctrl_out_1_o),
  .third_ctrl_out_2_o(third_ctrl_out_2_o), .third_ctrl_out_3_o(third_ctrl_out_3_o),
  .irq_o(irq_o));

// ==== tb/stage_ctrl_capture_irq_tb_top.sv ====
// Self-checking bench for the capture, output matrix and flag block.
`timescale 1ns/1ps
`include "scci_map.vh"

module stage_ctrl_capture_irq_tb_top;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc = 1'b0;
  logic        wb_we = 1'b0;
  logic [7:0]  wb_adr = 8'h00;
  logic [31:0] wb_dat = 32'h0000_0000;
  logic [31:0] rd_dat;
  logic        wb_ack;
  logic [35:0] cnt = 36'h0_0000_0000;
  logic [2:0]  pin = 3'h0, cyc_end = 3'h0, upd = 3'h0, auto = 3'h0, so0 = 3'h0, so1 = 3'h0;
  logic [5:0]  cmp = 6'h00, act = 6'h00, ramp = 6'h00;
  logic [3:0]  mtx;
  logic [2:0]  irq;
  logic [31:0] seed = 32'he4a4_8d5e;
  logic [7:0]  m;
  logic [7:0]  expq[$];
  logic [11:0] cap[3] = '{3{12'h000}};
  logic        trg[3] = '{3{1'b0}};
  logic [1:0]  rv[3] = '{3{2'h0}};
  int          err_count = 0, n_tests = 0, cycles = 0;

  // The strobe follows the cycle line; sel is tied because only byte lane 0 exists.
  scci_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_cyc),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_dat), .wb_dat_o(rd_dat),
    .wb_ack_o(wb_ack), .stage_counter_i(cnt), .stage_input_pin_i(pin), .comparator_i(cmp),
    .event_active_i(act), .cycle_end_i(cyc_end), .update_i(upd), .autorun_follow_i(auto),
    .stage_out_0_i(so0), .stage_out_1_i(so1), .ramp_index_i(ramp),
    .third_ctrl_out_0_o(mtx[0]), .third_ctrl_out_1_o(mtx[1]), .third_ctrl_out_2_o(mtx[2]),
    .third_ctrl_out_3_o(mtx[3]), .irq_o(irq));

  always #50 clk_i = ~clk_i;

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic report_and_stop;
    $display("Comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // One classic cycle; request held until ack is seen high at a rising edge.
  task automatic bus(input logic we, input logic [7:0] adr, input logic [7:0] d);
    int t;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_dat <= {24'h00_0000, d};
    t = 0;
    do begin
      @(posedge clk_i);
      t++;
    end while (wb_ack !== 1'b1 && t < 40);
    if (t == 40) err_count++;
    wb_cyc <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] adr, input logic [7:0] e);
    expq.push_back(e);
    bus(1'b0, adr, 8'h00);
  endtask

  // Read results are matched against the oldest note; the watchdog also lives here.
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (wb_ack === 1'b1 && wb_we === 1'b0) chk("read data", {24'h00_0000, expq.pop_front()}, rd_dat);
    if (cycles > 20000) begin
      err_count++;
      report_and_stop();
    end
  end

  // One qualified event on part b of controller n, from the pin or the comparator.
  task automatic ev(input int n, input int b, input logic sel, input logic en, input logic ion);
    logic [11:0] c;
    seed = lfsr(seed);
    c = seed[11:0];
    rv[n] = seed[13:12];
    cnt[12*n +: 12] <= c;
    ramp[2*n +: 2] <= rv[n];
    bus(1'b1, `SCCI_INPUT_CTRL0 + 8'(4*n), 8'({sel, en}) << (2*b));
    act[2*n+b] <= 1'b1;
    if (sel) cmp[2*n+b] <= 1'b1;
    else pin[n] <= 1'b1;
    // Sync chain plus filter is four cycles; eight leaves margin for the irq.
    repeat (8) @(posedge clk_i);
    chk("irq", ion, irq[n]);
    if (en) cap[n] = c;
    if (en) trg[n] = 1'b0;
    rd(`SCCI_FLAGS0 + 8'(4*n), {3'b000, b == 1, b == 0, rv[n], 1'b0});
    rd(`SCCI_CAP0_LOW + 8'(8*n), cap[n][7:0]);
    rd(`SCCI_CAP0_HIGH + 8'(8*n), {trg[n], 3'b000, cap[n][11:8]});
    cmp <= 6'h00;
    pin <= 3'h0;
    act <= 6'h00;
    bus(1'b1, `SCCI_FLAGS0 + 8'(4*n), 8'hff);
    rd(`SCCI_FLAGS0 + 8'(4*n), {5'h00, rv[n], 1'b0});
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int a = 0; a <= 'h44; a += 4) rd(8'(a), 8'h00);
    ev(0, 0, 1'b0, 1'b1, 1'b0);
    for (int n = 0; n < 3; n++) begin
      bus(1'b1, `SCCI_MASK0 + 8'(4*n), 8'hff);
      rd(`SCCI_MASK0 + 8'(4*n), `SCCI_MASK_USED);
    end
    ev(0, 1, 1'b1, 1'b1, 1'b1);
    ev(1, 0, 1'b0, 1'b0, 1'b1);
    ev(2, 1, 1'b0, 1'b1, 1'b1);
    ev(2, 0, 1'b1, 1'b1, 1'b1);
    // Software captures on all three, then a foreign low read splits a pair.
    for (int n = 0; n < 3; n++) begin
      seed = lfsr(seed);
      cnt[12*n +: 12] <= seed[11:0];
      cap[n] = seed[11:0];
      bus(1'b1, `SCCI_CAP0_HIGH + 8'(8*n), 8'h80);
    end
    bus(1'b1, `SCCI_CAP1_LOW, 8'h5a);
    rd(`SCCI_CAP0_LOW, cap[0][7:0]);
    rd(`SCCI_CAP2_LOW, cap[2][7:0]);
    rd(`SCCI_CAP0_HIGH, {4'h8, cap[2][11:8]});
    rd(`SCCI_CAP1_LOW, cap[1][7:0]);
    rd(`SCCI_CAP1_HIGH, {4'h8, cap[1][11:8]});
    // Hardware flag sources: output activity, sync error and cycle end.
    so0[0] <= 1'b1;
    so1[0] <= 1'b1;
    auto[1] <= 1'b1;
    upd[1] <= 1'b1;
    cyc_end[2] <= 1'b1;
    @(posedge clk_i);
    upd <= 3'h0;
    cyc_end <= 3'h0;
    repeat (3) @(posedge clk_i);
    chk("irq", 3'b110, irq);
    bus(1'b1, `SCCI_FLAGS0, 8'h00);
    rd(`SCCI_FLAGS0, {2'b11, 3'b000, rv[0], 1'b0});
    rd(`SCCI_FLAGS1, {3'b001, 2'b00, rv[1], 1'b0});
    rd(`SCCI_FLAGS2, {5'h00, rv[2], 1'b1});
    seed = lfsr(seed);
    m = seed[7:0];
    bus(1'b1, `SCCI_OUT_MATRIX, m);
    rd(`SCCI_OUT_MATRIX, m);
    for (int r = 0; r < 4; r++) begin
      ramp[5:4] <= 2'(r);
      repeat (3) @(posedge clk_i);
      chk("matrix a", m[r], mtx[0]);
      chk("matrix b", m[4+r], mtx[1]);
      chk("matrix a2", m[r], mtx[2]);
      chk("matrix b2", m[4+r], mtx[3]);
    end
    @(posedge clk_i);
    report_and_stop();
  end
endmodule // stage_ctrl_capture_irq_tb_top
